// file: lsm_params.svh
`ifndef LSM_PARAMS_SVH
`define LSM_PARAMS_SVH

// clock and timing
`define LSM_CLK_HZ 10000000
`define LSM_ONESHOT_MS 50
`define LSM_ONESHOT_CYC ((`LSM_ONESHOT_MS * `LSM_CLK_HZ) / 1000)
`define LSM_OSC_HZ 10000
`define LSM_OSC_HALF_CYC (`LSM_CLK_HZ / (2 * `LSM_OSC_HZ))

// positions in the synchronised input vector
`define LSM_IN_W 12
`define LSM_IN_AUTO 0
`define LSM_IN_UNIT 1
`define LSM_IN_LOCAL 2
`define LSM_IN_REQ2 3
`define LSM_IN_REQ3 4
`define LSM_IN_MOTOR 5
`define LSM_IN_TUNE 6
`define LSM_IN_SUP5 7
`define LSM_IN_SUP12 8
`define LSM_IN_CONT 9
`define LSM_IN_LINE2 10
`define LSM_IN_LINE3 11

// reset values
`define LSM_IN_RST 12'hc00
`define LSM_LAMP_RST 4'he
`define LSM_SEL_RST 2'h0

`endif

// file: lsm_pkg.sv
package lsm_pkg;
  typedef enum logic [1:0] {
    LSM_MODE_IDLE,
    LSM_MODE_LOCAL,
    LSM_MODE_AUTO
  } lsm_mode_e;
  typedef logic [1:0] lsm_line_t;
endpackage : lsm_pkg

// file: lsm_sync.sv
`timescale 1ns/1ps
`default_nettype none
module lsm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] ff1_reg;
  logic [W-1:0] ff2_reg;
  logic [W-1:0] ff3_reg;
  logic [W-1:0] out_reg;
  logic [W-1:0] out_next;

  // a bit moves only once the second and third stages agree
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      out_next[i] = (ff2_reg[i] == ff3_reg[i]) ? ff3_reg[i] : out_reg[i];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ff1_reg <= RST_VAL;
      ff2_reg <= RST_VAL;
      ff3_reg <= RST_VAL;
      out_reg <= RST_VAL;
    end
    else
    begin
      ff1_reg <= async_in;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
      out_reg <= out_next;
    end
  end

  assign sync_out = out_reg;
endmodule : lsm_sync
`default_nettype wire

// file: lsm_lamp_decode.sv
`timescale 1ns/1ps
`default_nettype none
module lsm_lamp_decode
  import lsm_pkg::*;
(
  // sensed line levels, high means open
  input wire lsm_line_t line_high,
  // active-low lamps, bit 0 is length one
  output logic [3:0] lamp_b
);
  logic [1:0] length_idx;

  always_comb
  begin
    length_idx = {~line_high[1], ~line_high[0]};
    lamp_b = ~(4'h1 << length_idx);
  end
endmodule : lsm_lamp_decode
`default_nettype wire

// file: lsm_line_switch.sv
`timescale 1ns/1ps
`default_nettype none
`include "lsm_params.svh"
// What this block does
// - each oscillator rising edge loads pending line-two and line-three requests.
// - stored line-two one pulls the line-two pin low; zero lets it float.
// - line two chosen means line-two pin low, line-three pin open.
// - pins encode length: 1 both high, 2 line-two low, 3 line-three low, 4 both.
// - automatic selection needs the auto button and an attached line switching unit.
// - entering automatic forces requests low, clocking zeros so outputs release.
// - entering automatic with both outputs released causes no one-shot or clocking.
// - request versus stored mismatch triggers the retriggerable one-shot enabling the oscillator.
// - ready low only with motor stopped and tune pulse seen since motor start.
// - motor start clears the tune latch unless the tune input is high in that cycle; ready high while clear or running.
// - tune input high sets the latch; ready falls after it drops, motor stopped.
// - line pins drive in manual mode, are monitored inputs in automatic mode.
// - decoder lights exactly one of four active-low lamps from sensed line levels.
// - mute rests high and goes low whenever the amplifier must be silenced.
// - mute low for the whole time the filter motor runs.
// - mute low through the one-shot period; retriggers extend it continuously.
// - fault low on any supply failure, and fault low forces mute low.
// - fault suppressed while the main power contactor is off.
// - each trigger enables the oscillator about 50 ms at about 10 kHz.
// - manual requests are accepted only while the local button is active.
module lsm_line_switch
  import lsm_pkg::*;
#(
  parameter int ONESHOT_CYC = `LSM_ONESHOT_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // front panel and system inputs
  input wire logic auto_button,
  input wire logic ext_unit_present,
  input wire logic local_button,
  input wire logic sel_line2_btn,
  input wire logic sel_line3_btn,
  input wire logic motor_run_sense,
  input wire logic tune_init,
  input wire logic supply_5v_ok,
  input wire logic supply_12v_ok,
  input wire logic contactor_on,
  // open-drain line pins
  input wire logic line2_i,
  output logic line2_o,
  output logic line2_oe_b,
  input wire logic line3_i,
  output logic line3_o,
  output logic line3_oe_b,
  // status outputs, all active low
  output logic ready_b,
  output logic mute_b,
  output logic fault_b,
  output logic [3:0] lamp_b
);
  logic [`LSM_IN_W-1:0] in_s;
  lsm_line_t sense_s;
  logic [3:0] lamp_dec;
  logic auto_mode;
  logic motor_s;
  logic tune_s;

  lsm_sync #(
    .W(`LSM_IN_W),
    .RST_VAL(`LSM_IN_RST)
  ) u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .async_in({line3_i, line2_i, contactor_on, supply_12v_ok, supply_5v_ok, tune_init,
               motor_run_sense, sel_line3_btn, sel_line2_btn, local_button,
               ext_unit_present, auto_button}),
    .sync_out(in_s)
  );

  assign sense_s = {in_s[`LSM_IN_LINE3], in_s[`LSM_IN_LINE2]};
  assign motor_s = in_s[`LSM_IN_MOTOR];
  assign tune_s = in_s[`LSM_IN_TUNE];
  assign auto_mode = in_s[`LSM_IN_AUTO] & in_s[`LSM_IN_UNIT];

  lsm_lamp_decode u_lamp (
    .line_high(sense_s),
    .lamp_b(lamp_dec)
  );

  // selection path: requests, change detect, one-shot, oscillator
  lsm_line_t sel_reg;
  lsm_line_t sel_next;
  lsm_line_t pend;
  lsm_line_t mismatch_reg;
  lsm_line_t mismatch_next;
  logic trigger;
  logic [19:0] shot_cnt_reg;
  logic [19:0] shot_cnt_next;
  logic shot_active;
  logic [9:0] osc_cnt_reg;
  logic [9:0] osc_cnt_next;
  logic osc_lvl_reg;
  logic osc_lvl_next;
  logic osc_rise;

  always_comb
  begin
    lsm_mode_e mode;
    mode = LSM_MODE_IDLE;
    if (auto_mode)
    begin
      mode = LSM_MODE_AUTO;
    end
    else if (in_s[`LSM_IN_LOCAL])
    begin
      mode = LSM_MODE_LOCAL;
    end
    case (mode)
      LSM_MODE_AUTO: pend = 2'h0;
      LSM_MODE_LOCAL: pend = {in_s[`LSM_IN_REQ3], in_s[`LSM_IN_REQ2]};
      LSM_MODE_IDLE: pend = sel_reg;
      default: pend = sel_reg;
    endcase
    mismatch_next = pend ^ sel_reg;
    // new difference only; no difference means no action
    trigger = |(mismatch_next & ~mismatch_reg);
    shot_active = (shot_cnt_reg != 20'h00000);
    shot_cnt_next = shot_cnt_reg;
    if (trigger)
    begin
      shot_cnt_next = 20'(ONESHOT_CYC);
    end
    else if (shot_active)
    begin
      shot_cnt_next = shot_cnt_reg - 20'h00001;
    end
    osc_cnt_next = 10'h000;
    osc_lvl_next = 1'b0;
    osc_rise = 1'b0;
    if (shot_active)
    begin
      osc_cnt_next = osc_cnt_reg + 10'h001;
      osc_lvl_next = osc_lvl_reg;
      if (osc_cnt_reg == 10'(`LSM_OSC_HALF_CYC - 1))
      begin
        osc_cnt_next = 10'h000;
        osc_lvl_next = ~osc_lvl_reg;
        osc_rise = ~osc_lvl_reg;
      end
    end
    sel_next = osc_rise ? pend : sel_reg;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sel_reg <= `LSM_SEL_RST;
      mismatch_reg <= 2'h0;
      shot_cnt_reg <= 20'h00000;
      osc_cnt_reg <= 10'h000;
      osc_lvl_reg <= 1'b0;
    end
    else
    begin
      sel_reg <= sel_next;
      mismatch_reg <= mismatch_next;
      shot_cnt_reg <= shot_cnt_next;
      osc_cnt_reg <= osc_cnt_next;
      osc_lvl_reg <= osc_lvl_next;
    end
  end

  // tune latch, ready, mute, fault, pins and lamps
  logic motor_prev_reg;
  logic motor_prev_next;
  logic tune_latch_reg;
  logic tune_latch_next;
  logic ready_b_reg;
  logic ready_b_next;
  logic mute_b_reg;
  logic mute_b_next;
  logic fault_b_reg;
  logic fault_b_next;
  lsm_line_t oe_b_reg;
  lsm_line_t oe_b_next;
  lsm_line_t line_o_reg;
  lsm_line_t line_o_next;
  logic [3:0] lamp_b_reg;
  logic [3:0] lamp_b_next;

  always_comb
  begin
    tune_latch_next = tune_latch_reg;
    if (motor_s && !motor_prev_reg)
    begin
      tune_latch_next = 1'b0;
    end
    if (tune_s)
    begin
      tune_latch_next = 1'b1;
    end
    ready_b_next = ~(tune_latch_reg & ~motor_s & ~tune_s);
    fault_b_next = ~((~in_s[`LSM_IN_SUP5] | ~in_s[`LSM_IN_SUP12]) & in_s[`LSM_IN_CONT]);
    mute_b_next = ~(motor_s | shot_active | ~fault_b_next);
    // pins released in automatic so the external unit drives them
    oe_b_next = auto_mode ? 2'h3 : ~sel_reg;
    motor_prev_next = motor_s;
    line_o_next = 2'h0;
    lamp_b_next = lamp_dec;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      motor_prev_reg <= 1'b0;
      tune_latch_reg <= 1'b0;
      ready_b_reg <= 1'b1;
      mute_b_reg <= 1'b1;
      fault_b_reg <= 1'b1;
      oe_b_reg <= 2'h3;
      line_o_reg <= 2'h0;
      lamp_b_reg <= `LSM_LAMP_RST;
    end
    else
    begin
      motor_prev_reg <= motor_prev_next;
      tune_latch_reg <= tune_latch_next;
      ready_b_reg <= ready_b_next;
      mute_b_reg <= mute_b_next;
      fault_b_reg <= fault_b_next;
      oe_b_reg <= oe_b_next;
      line_o_reg <= line_o_next;
      lamp_b_reg <= lamp_b_next;
    end
  end

  assign line2_o = line_o_reg[0];
  assign line3_o = line_o_reg[1];
  assign line2_oe_b = oe_b_reg[0];
  assign line3_oe_b = oe_b_reg[1];
  assign ready_b = ready_b_reg;
  assign mute_b = mute_b_reg;
  assign fault_b = fault_b_reg;
  assign lamp_b = lamp_b_reg;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  capture_on_edge_a: assert property (osc_rise |=> sel_reg == $past(pend))
    else $error("selection not loaded on oscillator edge");
  drive_low_a: assert property (sel_reg[0] && !auto_mode |=> !line2_oe_b)
    else $error("line two not driven while selected");
  auto_release_a: assert property (auto_mode |=> line2_oe_b && line3_oe_b)
    else $error("line pins driven in automatic mode");
  auto_zero_a: assert property (auto_mode |-> pend == 2'h0)
    else $error("automatic mode kept a request");
  auto_idle_a: assert property ($rose(auto_mode) && sel_reg == 2'h0 |-> !trigger [*2])
    else $error("one-shot fired with lines released");
  shot_load_a: assert property (trigger |=> shot_cnt_reg == 20'(ONESHOT_CYC))
    else $error("one-shot not loaded on change");
  ready_cause_a: assert property (!ready_b |-> $past(tune_latch_reg) && !$past(motor_s))
    else $error("ready low without tune or with motor");
  latch_clear_a: assert property ($rose(motor_s) && !tune_s |=> !tune_latch_reg)
    else $error("tune latch not cleared on motor start");
  motor_mute_a: assert property (motor_s |=> !mute_b)
    else $error("mute high with motor running");
  shot_mute_a: assert property (shot_active |=> !mute_b)
    else $error("mute high during one-shot");
  fault_mute_a: assert property (!fault_b |-> !mute_b)
    else $error("fault without mute");
  contactor_off_a: assert property (!in_s[`LSM_IN_CONT] |=> fault_b)
    else $error("fault shown with contactor off");
  one_lamp_a: assert property ($onehot(~lamp_b))
    else $error("not exactly one lamp lit");
  // pin drive, lamp map and timing in more detail
  line_two_a: assert property (sel_reg == 2'h1 && !auto_mode |=> !line2_oe_b && line3_oe_b)
    else $error("line two choice did not drive only line two");
  release_open_a: assert property (!sel_reg[0] && !auto_mode |=> line2_oe_b)
    else $error("line two driven while not selected");
  drive_three_a: assert property (sel_reg[1] && !auto_mode |=> !line3_oe_b)
    else $error("line three not driven while selected");
  length_one_a: assert property (sense_s == 2'h3 |=> lamp_b == 4'he)
    else $error("both lines open but length one lamp dark");
  length_four_a: assert property (sense_s == 2'h0 |=> lamp_b == 4'h7)
    else $error("both lines low but length four lamp dark");
  local_only_a: assert property (!in_s[`LSM_IN_LOCAL] && !auto_mode |-> pend == sel_reg)
    else $error("request taken without local button");
  tune_set_a: assert property (tune_s |=> tune_latch_reg)
    else $error("tune pulse did not set latch");
  motor_ready_a: assert property (motor_s |=> ready_b)
    else $error("ready low with motor running");
  mute_rest_a: assert property (!motor_s && !shot_active && fault_b_next |=> mute_b)
    else $error("mute low with no cause");
  osc_gate_a: assert property (!shot_active |-> !osc_rise)
    else $error("oscillator edge outside one-shot");
  shot_reload_a: assert property (trigger && shot_active |=> shot_cnt_reg == ONESHOT_CYC)
    else $error("retrigger did not extend one-shot");
  supply_fault_a: assert property (in_s[`LSM_IN_CONT] && !in_s[`LSM_IN_SUP5] |=> !fault_b)
    else $error("supply failure without fault");
  auto_clear_a: assert property (auto_mode && osc_rise |=> sel_reg == 2'h0)
    else $error("automatic mode did not clock zeros");
endmodule : lsm_line_switch
`default_nettype wire

// file: lsm_ext_unit.sv
`timescale 1ns/1ps
`default_nettype none
module lsm_ext_unit (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // handshake with the amplifier
  input wire logic ready_b,
  input wire logic auto_on,
  // relay command, a set bit pulls that line low
  input wire logic [1:0] cmd,
  output logic [1:0] pull
);
  logic [1:0] pull_reg;
  logic [1:0] pull_next;

  always_comb
  begin
    pull_next = pull_reg;
    if (!auto_on)
      pull_next = 2'h0;
    else if (!ready_b)
      pull_next = cmd;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      pull_reg <= 2'h0;
    else
      pull_reg <= pull_next;
  end

  assign pull = pull_reg;
endmodule : lsm_ext_unit
`default_nettype wire

// file: lsm_line_switch_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lsm_line_switch_tb;
  typedef struct {int sel; logic [3:0] exp;} lsm_note_s;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic auto_btn = 1'b0, unit = 1'b0, local_btn = 1'b0, s2 = 1'b0, s3 = 1'b0;
  logic motor = 1'b0, tune = 1'b0, ok5 = 1'b1, ok12 = 1'b1, cont = 1'b1;
  logic [1:0] cmd = 2'h0;
  logic [1:0] pull;
  logic l2_o, l2_oe_b, l3_o, l3_oe_b, ready_b, mute_b, fault_b;
  logic [3:0] lamp_b;
  logic [31:0] seed = 32'h3488;
  logic [31:0] r;
  int fails = 0;
  int compares = 0;
  lsm_note_s q[$];
  lsm_note_s n;
  event look;
  // pin wire: idles high, low when either side (amplifier or relays) sinks it
  wire logic l2_i = !((!l2_oe_b && !l2_o) || pull[0]);
  wire logic l3_i = !((!l3_oe_b && !l3_o) || pull[1]);

  always #50 core_clk = ~core_clk;

  lsm_line_switch #(.ONESHOT_CYC(2000)) dut (
    .core_clk(core_clk), .rst_b(rst_b), .auto_button(auto_btn), .ext_unit_present(unit),
    .local_button(local_btn), .sel_line2_btn(s2), .sel_line3_btn(s3),
    .motor_run_sense(motor), .tune_init(tune), .supply_5v_ok(ok5), .supply_12v_ok(ok12),
    .contactor_on(cont), .line2_i(l2_i), .line2_o(l2_o), .line2_oe_b(l2_oe_b),
    .line3_i(l3_i), .line3_o(l3_o), .line3_oe_b(l3_oe_b), .ready_b(ready_b),
    .mute_b(mute_b), .fault_b(fault_b), .lamp_b(lamp_b));

  lsm_ext_unit unit_m (.core_clk(core_clk), .rst_b(rst_b), .ready_b(ready_b),
    .auto_on(auto_btn && unit), .cmd(cmd), .pull(pull));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [3:0] obs(input int sel);
    case (sel)
      0: return lamp_b;
      1: return {l3_o, l2_o, l3_oe_b, l2_oe_b};
      2: return {3'h0, ready_b};
      3: return {3'h0, mute_b};
      default: return {3'h0, fault_b};
    endcase
  endfunction : obs

  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask : cyc

  task automatic note(input int sel, input logic [3:0] exp);
    q.push_back('{sel, exp});
    -> look;
  endtask : note

  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out();
    if (fails == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  // local selection of one length, then mute release
  task automatic step(input logic [1:0] c);
    {s3, s2} = c;
    cyc(10);
    note(3, 4'h0);
    cyc(690);
    note(1, {2'h0, ~c});
    note(0, ~(4'h1 << c));
    cyc(1500);
    note(3, 4'h1);
  endtask : step

  initial
  begin
    forever
    begin
      @(look);
      while (q.size() != 0)
      begin
        n = q.pop_front();
        chk(obs(n.sel), n.exp);
      end
    end
  end

  initial
  begin
    #(60000 * 100);
    fails++;
    close_out();
  end

  initial
  begin
    cyc(19);
    for (int i = 0; i < 5; i++)
      note(i, i == 0 ? 4'he : (i == 1 ? 4'h3 : 4'h1));
    cyc(1);
    rst_b = 1'b1;
    local_btn = 1'b1;
    for (int i = 1; i < 5; i++)
      step(i == 3 ? 2'h0 : (i == 4 ? 2'h3 : i[1:0]));
    local_btn = 1'b0;
    r = xs();
    {s3, s2} = r[1:0];
    cyc(700);
    note(1, 4'h0);
    note(3, 4'h1);
    cmd = 2'h2;
    auto_btn = 1'b1;
    unit = 1'b1;
    cyc(10);
    note(3, 4'h0);
    cyc(690);
    note(1, 4'h3);
    note(0, 4'he);
    cyc(1500);
    tune = 1'b1;
    cyc(10);
    tune = 1'b0;
    cyc(10);
    note(2, 4'h0);
    motor = 1'b1;
    cyc(10);
    note(3, 4'h0);
    note(2, 4'h1);
    motor = 1'b0;
    cyc(10);
    note(2, 4'h1);
    tune = 1'b1;
    cyc(10);
    note(2, 4'h1);
    tune = 1'b0;
    cyc(10);
    note(2, 4'h0);
    cyc(10);
    note(0, 4'hb);
    auto_btn = 1'b0;
    cyc(10);
    note(0, 4'he);
    auto_btn = 1'b1;
    cyc(10);
    note(3, 4'h1);
    auto_btn = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      {cont, ok12, ok5} = i[2:0];
      cyc(10);
      note(4, (i[2] && i[1:0] != 2'h3) ? 4'h0 : 4'h1);
      note(3, (i[2] && i[1:0] != 2'h3) ? 4'h0 : 4'h1);
    end
    cyc(2);
    close_out();
  end
endmodule : lsm_line_switch_tb
`default_nettype wire
